// ### core/lpc_defines.svh
// Constants for the channel printer controller: fields, codes, resets
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH
// Instruction function codes on io_func
`define LPC_FN_NIO        3'h0
`define LPC_FN_LOAD_FMT   3'h1
`define LPC_FN_LOAD_ADDR  3'h2
`define LPC_FN_LOAD_COUNT 3'h3
`define LPC_FN_READ_STAT  3'h4
`define LPC_FN_READ_ADDR  3'h5
`define LPC_FN_READ_COUNT 3'h6
// Flag control codes on io_flag
`define LPC_FLAG_NONE     2'h0
`define LPC_FLAG_START    2'h1
`define LPC_FLAG_CLEAR    2'h2
`define LPC_FLAG_PULSE    2'h3
// Accumulator fields, bit 0 is the most significant bit of the word
`define LPC_ACC_FMT_BIT   15
`define LPC_ACC_BP_BIT    0
`define LPC_STAT_CHG_BIT  2
`define LPC_STAT_RDY_BIT  1
// Reset values
`define LPC_RST_COUNT     16'h0000
`define LPC_RST_ADDR      15'h0000
`define LPC_RST_FMT_DIS   1'b1
// Default device code, arbitrary value
`define LPC_DEV_CODE      6'h0F
`endif

// ### core/lpc_pkg.sv
// Types shared by the channel printer controller
package lpc_pkg;
	typedef enum logic [1:0] {
		LPC_IDLE,
		LPC_FETCH,
		LPC_SEND
	} lpc_state_type;
endpackage

// ### core/lpc_edge.sv
// Change detector for the printer ready line
module lpc_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Watched level and change pulse
	input  wire logic level_in,
	output logic      changed
);
	logic last;
	logic primed;

	// Prime after reset so the first sample raises no false change
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last   <= 1'b0;
			primed <= 1'b0;
		end else begin
			last   <= level_in;
			primed <= 1'b1;
		end
	end

	assign changed = primed & (last != level_in);
endmodule

// ### core/lpc_top.sv
// Data channel line printer controller: I/O bus side, channel fetch, byte unpacker
//
// Contract
// - Read-count returns full 16-bit two's-complement remaining count in bits 0-15.
// - After returning the count, busy and done follow that instruction's flag field.
// - Block data is fetched by data channel, each word holding two bytes.
// - One block may hold up to 65,536 bytes, that is 32,768 words; a zero count starts no transfer, so at most 65,535 bytes move.
// - Data movement begins only on the start flag command.
// - Words unpack high byte (bits 0-7) first; each byte strobed separately.
// - When all bytes are moved, request a data channel completion interrupt.
// - Byte indicator zero starts at high byte; one starts at low byte.
// - Starting low skips first word's high byte, then next word's high byte.
// - Odd count from high, even from low: only final word's high byte.
// - Any ready line change sets status-change flag and raises program interrupt.
// - Read-status presents status-change flag in accumulator bit 13.
// - Start sets busy, clears done, and begins the block transfer.
// - Clear zeroes busy, done and status-change, stopping any operation.
// - System I/O clear acts as clear, sets format disable, zeroes counters.
`include "lpc_defines.svh"
module lpc_top
	import lpc_pkg::*;
#(
	parameter logic [5:0] DEV_CODE = `LPC_DEV_CODE
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Processor I/O bus instruction port
	input  wire logic        io_strobe,
	input  wire logic [5:0]  io_device,
	input  wire logic [2:0]  io_func,
	input  wire logic [1:0]  io_flag,
	input  wire logic [15:0] io_wdata,
	input  wire logic        system_io_clear,
	output logic [15:0]      io_rdata,
	output logic             io_rvalid,
	// Data channel read port
	output logic             dch_req,
	output logic [14:0]      dch_addr,
	input  wire logic        dch_ack,
	input  wire logic [15:0] dch_data,
	// Printer side
	input  wire logic        prn_ready,
	output logic             prn_strobe,
	output logic [7:0]       prn_data,
	// Status and interrupts
	output logic             busy,
	output logic             done,
	output logic             status_change,
	output logic             format_disable,
	output logic             prog_irq,
	output logic             dch_irq
);
	lpc_state_type state;
	logic [15:0]   transfer_length_count;
	logic [14:0]   word_addr;
	logic          byte_ptr;
	logic [15:0]   word_buf;
	logic          sel;
	logic          clear_cmd;
	logic          start_cmd;
	logic          ready_changed;
	logic          last_byte;
	logic [15:0]   next_count;

	// Instruction decode; the flag field acts after the data part of the same cycle
	assign sel       = io_strobe && (io_device == DEV_CODE);
	assign clear_cmd = system_io_clear || (sel && io_flag == `LPC_FLAG_CLEAR);
	assign start_cmd = sel && io_flag == `LPC_FLAG_START;
	assign next_count = transfer_length_count + 16'h0001;
	assign last_byte  = (next_count == 16'h0000);

	// Ready line watcher
	lpc_edge u_ready_watch (
		.clk      (clk),
		.rst_n    (rst_n),
		.level_in (prn_ready),
		.changed  (ready_changed)
	);

	// Read data; registered so the answer appears one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			io_rdata  <= 16'h0000;
			io_rvalid <= 1'b0;
		end else begin
			io_rvalid <= 1'b0;
			if (sel) begin
				case (io_func)
					`LPC_FN_READ_COUNT: begin
						io_rdata  <= transfer_length_count;
						io_rvalid <= 1'b1;
					end
					`LPC_FN_READ_STAT: begin
						io_rdata  <= 16'h0000;
						io_rdata[`LPC_STAT_CHG_BIT] <= status_change;
						io_rdata[`LPC_STAT_RDY_BIT] <= prn_ready;
						io_rvalid <= 1'b1;
					end
					`LPC_FN_READ_ADDR: begin
						io_rdata  <= {word_addr, byte_ptr};
						io_rvalid <= 1'b1;
					end
					default: begin
						io_rdata <= io_rdata;
					end
				endcase
			end
		end
	end

	// Format disable flag; bit 0 of the word sits in the msb
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			format_disable <= `LPC_RST_FMT_DIS;
		end else if (system_io_clear) begin
			format_disable <= `LPC_RST_FMT_DIS;
		end else if (sel && io_func == `LPC_FN_LOAD_FMT) begin
			format_disable <= io_wdata[`LPC_ACC_FMT_BIT];
		end
	end

	// Status change flag; a new change wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_change <= 1'b0;
		end else if (ready_changed) begin
			status_change <= 1'b1;
		end else if (clear_cmd) begin
			status_change <= 1'b0;
		end
	end

	// Program interrupt follows done or a pending status change
	assign prog_irq = done | status_change;

	// Counter, address and byte pointer: loads and per-byte updates
	always_ff @(posedge clk) begin
		if (!rst_n || system_io_clear) begin
			transfer_length_count <= `LPC_RST_COUNT;
			word_addr             <= `LPC_RST_ADDR;
			byte_ptr              <= 1'b0;
		end else if (state == LPC_SEND) begin
			transfer_length_count <= next_count;
			if (byte_ptr || last_byte) begin
				word_addr <= word_addr + 15'h0001;
				byte_ptr  <= 1'b0;
			end else begin
				byte_ptr <= 1'b1;
			end
		end else if (sel && state == LPC_IDLE) begin
			// Loads accepted only between blocks so a running block stays coherent
			if (io_func == `LPC_FN_LOAD_ADDR) begin
				word_addr <= io_wdata[15:1];
				byte_ptr  <= io_wdata[`LPC_ACC_BP_BIT];
			end else if (io_func == `LPC_FN_LOAD_COUNT) begin
				transfer_length_count <= io_wdata;
			end
		end
	end

	// Transfer sequencer: fetch a word when needed, then send bytes one by one
	always_ff @(posedge clk) begin
		if (!rst_n || clear_cmd) begin
			state <= LPC_IDLE;
		end else begin
			case (state)
				LPC_IDLE: begin
					if (start_cmd && transfer_length_count != 16'h0000) begin
						state <= LPC_FETCH;
					end
				end
				LPC_FETCH: begin
					if (dch_ack) begin
						state <= LPC_SEND;
					end
				end
				LPC_SEND: begin
					if (last_byte) begin
						state <= LPC_IDLE;
					end else if (byte_ptr) begin
						state <= LPC_FETCH;
					end else begin
						state <= LPC_SEND;
					end
				end
				default: begin
					state <= LPC_IDLE;
				end
			endcase
		end
	end

	// Fetched word holding register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			word_buf <= 16'h0000;
		end else if (state == LPC_FETCH && dch_ack) begin
			word_buf <= dch_data;
		end
	end

	assign dch_req  = (state == LPC_FETCH);
	assign dch_addr = word_addr;

	// Byte strobe; high byte (bits 0-7, the upper lane) goes first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prn_strobe <= 1'b0;
			prn_data   <= 8'h00;
		end else begin
			prn_strobe <= (state == LPC_SEND) && !clear_cmd;
			if (state == LPC_SEND) begin
				prn_data <= byte_ptr ? word_buf[7:0] : word_buf[15:8];
			end
		end
	end

	// Busy and done; flag field applies after any read of the same instruction
	always_ff @(posedge clk) begin
		if (!rst_n || clear_cmd) begin
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start_cmd) begin
			busy <= 1'b1;
			done <= 1'b0;
		end else if (state == LPC_SEND && last_byte) begin
			busy <= 1'b0;
			done <= 1'b1;
		end
	end

	// Completion interrupt pulse when the last byte leaves
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dch_irq <= 1'b0;
		end else begin
			dch_irq <= state == LPC_SEND && last_byte && !clear_cmd;
		end
	end
endmodule

// ### verification/lpc_top_props.sv
// Port-level checks for the channel printer controller
`include "lpc_defines.svh"
module lpc_props #(
	parameter logic [5:0] DEV_CODE = 6'h0F
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       io_strobe,
	input wire logic [5:0] io_device,
	input wire logic [2:0] io_func,
	input wire logic [1:0] io_flag,
	input wire logic       system_io_clear,
	input wire logic       io_rvalid,
	input wire logic       dch_req,
	input wire logic       prn_ready,
	input wire logic       prn_strobe,
	input wire logic       busy,
	input wire logic       done,
	input wire logic       status_change,
	input wire logic       format_disable,
	input wire logic       prog_irq,
	input wire logic       dch_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Accepted instruction with a given flag code
	sequence s_cmd(logic [1:0] f);
		io_strobe && io_device == DEV_CODE && io_flag == f;
	endsequence
	// Accepted read of status, address or count
	sequence s_read;
		io_strobe && io_device == DEV_CODE && io_func >= `LPC_FN_READ_STAT
			&& io_func <= `LPC_FN_READ_COUNT;
	endsequence
	AST_START_BUSY: assert property (s_cmd(`LPC_FLAG_START) && !system_io_clear |=> busy && !done)
		else $error("start did not set busy and drop done");
	AST_CLEAR_FLAGS: assert property (s_cmd(`LPC_FLAG_CLEAR) |=> !busy && !done)
		else $error("clear left busy or done set");
	AST_IO_CLEAR: assert property (system_io_clear |=> format_disable && !busy && !done)
		else $error("system clear did not clear flags");
	AST_READY_WATCH: assert property ($changed(prn_ready) |-> ##[1:3] status_change)
		else $error("ready change not flagged");
	AST_PROG_IRQ: assert property (prog_irq == (done || status_change))
		else $error("program interrupt wrong");
	AST_END_IRQ: assert property ($rose(done) |-> dch_irq ##1 !dch_irq)
		else $error("completion interrupt missing or long");
	AST_READ_ANSWER: assert property (s_read |=> io_rvalid)
		else $error("read not answered");
	AST_NO_EARLY_FETCH: assert property (dch_req |-> busy)
		else $error("fetch outside a block");
	AST_STROBE_IN_BLOCK: assert property (prn_strobe |-> busy || done || $past(busy))
		else $error("byte strobed outside a block");
endmodule

// ### verification/lpc_chan_model.sv
// Data channel memory model answering word fetches
module lpc_chan_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Fetch port and pace select
	input  wire logic        dch_req,
	input  wire logic [14:0] dch_addr,
	input  wire logic        slow,
	output logic             dch_ack,
	output logic [15:0]      dch_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] wait_cnt;
	// One word per request after one or five cycles; idle data toggles
	always_ff @(posedge clk) begin
		if (!rst_n || dch_ack || !dch_req) begin
			dch_ack  <= 1'b0;
			wait_cnt <= 3'h0;
			dch_data <= rst_n ? ~dch_data : 16'h5A5A;
		end else if (wait_cnt == (slow ? 3'h4 : 3'h0)) begin
			dch_ack  <= 1'b1;
			dch_data <= {dch_addr[7:0] ^ 8'hA5, dch_addr[7:0] ^ 8'h3C};
		end else begin
			wait_cnt <= wait_cnt + 3'h1;
			dch_data <= ~dch_data;
		end
	end
endmodule

// ### verification/lpc_top_tb.sv
// Self-checking bench for the channel printer controller
`include "lpc_defines.svh"
module lpc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] DEV = 6'h2A; // Arbitrary device code
	logic        clk = 1'b0, rst_n = 1'b0, io_strobe = 1'b0, system_io_clear = 1'b0;
	logic [5:0]  io_device = DEV;
	logic [2:0]  io_func = 3'h0;
	logic [1:0]  io_flag = 2'h0;
	logic [15:0] io_wdata = 16'h0000, io_rdata, dch_data;
	logic [14:0] dch_addr;
	logic [7:0]  prn_data, qb[$];
	logic [31:0] w, qw[$];
	logic        io_rvalid, dch_req, dch_ack, prn_strobe, busy, done, status_change;
	logic        format_disable, prog_irq, dch_irq, prn_ready = 1'b1, slow = 1'b0;
	int          mismatches = 0, n_checks = 0;
	always #2.5 clk = ~clk;
	lpc_top #(.DEV_CODE(DEV)) u_lpc_top (.*);
	lpc_chan_model u_lpc_chan_model (.*);
	task automatic tally(string s, bit ok, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (!ok) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cmp_byte(string s, logic [7:0] e, logic [7:0] g);
		tally(s, g === e, 16'(e), 16'(g));
	endtask
	task automatic cmp_word(string s, logic [15:0] e, logic [15:0] g);
		tally(s, g === e, e, g);
	endtask
	task automatic cmp_flag(string s, logic e, logic g);
		tally(s, g === e, 16'(e), 16'(g));
	endtask
	// Oldest note against each strobed byte or read answer; mid-cycle, off the launch edge
	always @(negedge clk) begin
		if (prn_strobe === 1'b1)
			cmp_byte("printer byte", qb.size() ? qb.pop_front() : 8'hXX, prn_data);
		if (io_rvalid === 1'b1) begin
			w = qw.size() ? qw.pop_front() : {16'hFFFF, 16'hXXXX};
			cmp_word("read word", w[15:0], io_rdata & w[31:16]);
		end
	end
	// One instruction, raised and dropped at falling edges, then one idle edge
	task automatic io(logic [2:0] f, logic [1:0] fl, logic [15:0] d);
		io_func = f;
		io_flag = fl;
		io_wdata = d;
		io_strobe = 1'b1;
		@(negedge clk);
		io_strobe = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(logic [2:0] f, logic [1:0] fl, logic [15:0] m, logic [15:0] e);
		qw.push_back({m, e & m});
		io(f, fl, 16'h0000);
	endtask
	task automatic launch(logic [14:0] a, bit bp, int n);
		io(`LPC_FN_LOAD_COUNT, `LPC_FLAG_NONE, 16'(-n));
		io(`LPC_FN_LOAD_ADDR, `LPC_FLAG_NONE, {a, bp});
		repeat (4) @(negedge clk);
		io(`LPC_FN_NIO, `LPC_FLAG_START, 16'h0000);
	endtask
	// Whole block: expected bytes follow the byte indicator and count parity
	task automatic block(logic [14:0] a, bit bp, int n);
		int k;
		for (k = 2 * a + bp; k < 2 * a + bp + n; k++)
			qb.push_back(k[0] ? (k[8:1] ^ 8'h3C) : (k[8:1] ^ 8'hA5));
		launch(a, bp, n);
		for (k = 0; k < 400 && done !== 1'b1; k++)
			@(negedge clk);
		repeat (3) @(negedge clk);
		cmp_flag("done", 1'b1, done);
		cmp_flag("busy", 1'b0, busy);
		cmp_flag("bytes left", 1'b1, qb.size() == 0);
		rd(`LPC_FN_READ_COUNT, `LPC_FLAG_CLEAR, 16'hFFFF, 16'h0000);
		rd(`LPC_FN_READ_ADDR, `LPC_FLAG_NONE, 16'hFFFE, {15'(a + (bp + n + 1) / 2), 1'b0});
		cmp_flag("done after read", 1'b0, done);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end
	initial begin
		int i;
		void'($urandom(84620));
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		for (i = 0; i < 8; i++) begin
			slow = i[0];
			block(15'($urandom), i[1], 2 * $urandom_range(2) + 1 + i[2]);
			$display("block %0d finished", i);
		end
		prn_ready = 1'b0;
		repeat (4) @(negedge clk);
		cmp_flag("status change", 1'b1, status_change);
		rd(`LPC_FN_READ_STAT, `LPC_FLAG_CLEAR, 16'hFFFF, 16'h0004);
		cmp_flag("status cleared", 1'b0, status_change);
		$display("status test finished");
		// Slow fetch so the system clear lands before any byte moves
		io(`LPC_FN_LOAD_FMT, `LPC_FLAG_NONE, 16'h0000);
		launch(15'h0005, 1'b0, 20);
		system_io_clear = 1'b1;
		@(negedge clk);
		system_io_clear = 1'b0;
		cmp_flag("format disable", 1'b1, format_disable);
		rd(`LPC_FN_READ_COUNT, `LPC_FLAG_NONE, 16'hFFFF, 16'h0000);
		rd(`LPC_FN_READ_ADDR, `LPC_FLAG_NONE, 16'hFFFF, 16'h0000);
		io(`LPC_FN_LOAD_FMT, `LPC_FLAG_NONE, 16'h8000);
		cmp_flag("format disable kept", 1'b1, format_disable);
		repeat (4) @(negedge clk);
		$display("system clear test finished");
		stop_test();
	end
endmodule
bind lpc_top lpc_props #(.DEV_CODE(DEV_CODE)) u_lpc_props (.*);
